// File: rtl/fps_regs.svh
// Purpose: Constants for the fault protection supervisor
// Assumes: Included by the design module and the testbench
// Notes: Avalon-MM byte offsets, field positions, reset values, counts
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// Register byte offsets
`define FPS_CTRL_OFS 4'h0
`define FPS_STAT_OFS 4'h4
`define FPS_CFG_OFS 4'h8

// Control register field positions
`define FPS_CTRL_EN_BIT 0
`define FPS_CTRL_POR_BIT 1

// Status register field positions
`define FPS_STAT_OK_BIT 0
`define FPS_STAT_OV_BIT 1
`define FPS_STAT_OC_BIT 2
`define FPS_STAT_UV_BIT 3
`define FPS_STAT_LOCK_BIT 4
`define FPS_STAT_CNT_LSB 8
`define FPS_STAT_ST_LSB 12

// Reset values
`define FPS_CTRL_RST 2'h0
`define FPS_CFG_RST 4'h1

// Timing counts in phase-clock pulses, and the hiccup retry limit
`define FPS_SS_CYCLES 12'h800
`define FPS_HICCUP_CYCLES 12'h800
`define FPS_MAX_RETRY 3'h7

// Analog references, in millivolts and microamps, for documentation of the comparators
`define FPS_UV_OFFSET_MV 350
`define FPS_OV_LEVEL_MV 2200
`define FPS_OC_REF_UA 90
`define FPS_REF_STEP_MV 25
`define FPS_EN_TH_MV 1230

`endif

// File: rtl/fps_pkg.sv
// Purpose: Types for the fault protection supervisor
// Assumes: fps_regs.svh holds all numeric constants
// Notes: Phase output state and fault state encodings
package fps_pkg;

   // Per-phase drive state
   typedef enum logic [1:0]
   {
      FPS_PH_NORMAL = 2'b00,
      FPS_PH_LOW = 2'b01,
      FPS_PH_HIZ = 2'b10
   } fps_phase_t;

   // Fault state machine
   typedef enum logic [2:0]
   {
      FPS_ST_SHUT = 3'b000,
      FPS_ST_SOFT = 3'b001,
      FPS_ST_RUN = 3'b010,
      FPS_ST_OCWAIT = 3'b011,
      FPS_ST_OVCLAMP = 3'b100,
      FPS_ST_OVHIZ = 3'b101,
      FPS_ST_LOCK = 3'b110
   } fps_state_t;

endpackage

// File: rtl/fps_supervisor.sv
// Purpose: Fault supervision for a multi-phase buck controller
// Assumes: Comparator results arrive synchronous to clk_sys
// Notes: Phase clock is a one-cycle enable pulse from a divider
`timescale 1ns/1ps
`include "fps_regs.svh"

module fps_supervisor #(
   parameter int NUM_PHASES = 4,
   parameter int PH_DIV = 25
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // Comparator inputs
   input wire logic enable_in,
   input wire logic por_ok_in,
   input wire logic uv_above_in,
   input wire logic ov_trip_in,
   input wire logic at_ref_in,
   input wire logic oc_trip_in,
   input wire logic ref_stepping_in,
   // Outputs
   output fps_pkg::fps_phase_t phase_state [NUM_PHASES],
   output logic supply_ok_out,
   output logic crowbar_trigger,
   output logic overcurrent_fault,
   output logic undervoltage_fault,
   output logic overvoltage_fault,
   output logic phase_clk_en
);
   import fps_pkg::*;

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   logic [1:0] ctrl_r; // Software enable and soft reset request
   logic [3:0] cfg_r; // Spare config, echoes back
   logic [7:0] div_r; // Phase clock divider
   fps_state_t state_r; // Fault state
   fps_state_t state_nxt; // Next fault state
   logic [11:0] cnt_r; // Soft-start and hiccup counter, 11 bits plus done
   logic [2:0] retry_r; // Hiccup retry counter
   logic ok_r; // Supply ok register
   logic ov_r; // Over-voltage latch
   logic ok_nxt; // Next supply ok
   logic oc_live; // Blanked over-current
   logic en_all; // Combined enable
   logic ack_r; // Bus answer cycle
   logic [31:0] rdata_r; // Read data register

   //------------------------------------------------------------
   // Phase clock divider
   //------------------------------------------------------------
   // One-cycle enable instead of a second clock
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         div_r <= 8'h00;
         phase_clk_en <= 1'b0;
      end
      else if (div_r == 8'(PH_DIV - 1))
      begin
         div_r <= 8'h00;
         phase_clk_en <= 1'b1;
      end
      else
      begin
         div_r <= div_r + 8'h01;
         phase_clk_en <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Qualifiers
   //------------------------------------------------------------
   // Pin enable and software enable both needed; POR gates all
   assign en_all = enable_in & ctrl_r[`FPS_CTRL_EN_BIT] & por_ok_in
                   & ~ctrl_r[`FPS_CTRL_POR_BIT];
   // Comparator ignored while reference is stepping
   assign oc_live = oc_trip_in & ~ref_stepping_in;

   //------------------------------------------------------------
   // Fault state machine
   //------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         FPS_ST_SHUT:
         begin
            if (en_all)
            begin
               state_nxt = FPS_ST_SOFT;
            end
         end
         FPS_ST_SOFT:
         begin
            if (ov_trip_in)
            begin
               state_nxt = FPS_ST_OVCLAMP;
            end
            else if (oc_live)
            begin
               // Eighth failed attempt latches off
               if (retry_r == `FPS_MAX_RETRY)
               begin
                  state_nxt = FPS_ST_LOCK;
               end
               else
               begin
                  state_nxt = FPS_ST_OCWAIT;
               end
            end
            else if (cnt_r == `FPS_SS_CYCLES)
            begin
               state_nxt = FPS_ST_RUN;
            end
         end
         FPS_ST_RUN:
         begin
            if (ov_trip_in)
            begin
               state_nxt = FPS_ST_OVCLAMP;
            end
            else if (oc_live)
            begin
               state_nxt = FPS_ST_OCWAIT;
            end
         end
         FPS_ST_OCWAIT:
         begin
            if (ov_trip_in)
            begin
               state_nxt = FPS_ST_OVCLAMP;
            end
            else if (cnt_r == `FPS_HICCUP_CYCLES)
            begin
               state_nxt = FPS_ST_SOFT;
            end
         end
         FPS_ST_OVCLAMP:
         begin
            // Clamp until output falls to reference
            if (at_ref_in && !ov_trip_in)
            begin
               state_nxt = FPS_ST_OVHIZ;
            end
         end
         FPS_ST_OVHIZ:
         begin
            if (ov_trip_in)
            begin
               state_nxt = FPS_ST_OVCLAMP;
            end
         end
         FPS_ST_LOCK:
         begin
            if (ov_trip_in)
            begin
               state_nxt = FPS_ST_OVCLAMP;
            end
         end
         default:
         begin
            state_nxt = FPS_ST_SHUT;
         end
      endcase
      // Disable returns to shutdown; latches only cleared here
      if (!en_all)
      begin
         state_nxt = FPS_ST_SHUT;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= FPS_ST_SHUT;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   //------------------------------------------------------------
   // Soft-start and hiccup counter
   //------------------------------------------------------------
   // Restarts on every state change, counts phase pulses
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= 12'h000;
      end
      else if (state_nxt != state_r)
      begin
         cnt_r <= 12'h000;
      end
      else if (phase_clk_en && cnt_r != `FPS_SS_CYCLES)
      begin
         cnt_r <= cnt_r + 12'h001;
      end
   end

   //------------------------------------------------------------
   // Retry counter
   //------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         retry_r <= 3'h0;
      end
      else if (state_nxt == FPS_ST_SHUT || state_nxt == FPS_ST_RUN)
      begin
         retry_r <= 3'h0;
      end
      else if (state_r == FPS_ST_SOFT && state_nxt == FPS_ST_OCWAIT)
      begin
         retry_r <= retry_r + 3'h1;
      end
   end

   //------------------------------------------------------------
   // Over-voltage latch and crowbar
   //------------------------------------------------------------
   // Held until disable or POR; set wins over clear
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ov_r <= 1'b0;
      end
      else if (ov_trip_in && state_r != FPS_ST_SHUT)
      begin
         ov_r <= 1'b1;
      end
      else if (!en_all)
      begin
         ov_r <= 1'b0;
      end
   end
   assign overvoltage_fault = ov_r;
   assign crowbar_trigger = ov_r;

   //------------------------------------------------------------
   // Supply ok
   //------------------------------------------------------------
   // Threshold tracks the reference through the offset comparator
   always_comb
   begin
      ok_nxt = 1'b0;
      case (state_r)
         FPS_ST_SOFT:
         begin
            ok_nxt = uv_above_in && !oc_live;
         end
         FPS_ST_RUN:
         begin
            ok_nxt = uv_above_in;
         end
         FPS_ST_SHUT:
         begin
            // Disabled while good: hold until decay
            ok_nxt = ok_r && uv_above_in && !ov_r;
         end
         default:
         begin
            ok_nxt = 1'b0;
         end
      endcase
      if (ov_trip_in)
      begin
         ok_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ok_r <= 1'b0;
      end
      else
      begin
         ok_r <= ok_nxt;
      end
   end
   assign supply_ok_out = ok_r;
   assign undervoltage_fault = ~uv_above_in;
   assign overcurrent_fault = (state_r == FPS_ST_OCWAIT) || (state_r == FPS_ST_LOCK);

   //------------------------------------------------------------
   // Phase outputs
   //------------------------------------------------------------
   // Same state on every phase
   generate
      for (genvar g = 0; g < NUM_PHASES; g++)
      begin : g_phase
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               phase_state[g] <= FPS_PH_HIZ;
            end
            else if (state_nxt == FPS_ST_OVCLAMP)
            begin
               phase_state[g] <= FPS_PH_LOW;
            end
            else if (state_nxt == FPS_ST_SOFT || state_nxt == FPS_ST_RUN)
            begin
               phase_state[g] <= FPS_PH_NORMAL;
            end
            else
            begin
               phase_state[g] <= FPS_PH_HIZ;
            end
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Avalon-MM slave
   //------------------------------------------------------------
   // One wait cycle, then answer; unmapped reads zero with error
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

   // Register writes take effect at the accepting edge
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r <= `FPS_CTRL_RST;
         cfg_r <= `FPS_CFG_RST;
      end
      else if (avs_write && ack_r && avs_byteenable[0])
      begin
         if (avs_address == `FPS_CTRL_OFS)
         begin
            ctrl_r <= avs_writedata[1:0];
         end
         else if (avs_address == `FPS_CFG_OFS)
         begin
            cfg_r <= avs_writedata[3:0];
         end
      end
   end

   // Read data prepared in the wait cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_r <= 32'h0000_0000;
         avs_response <= 2'b00;
      end
      else if (!ack_r)
      begin
         rdata_r <= 32'h0000_0000;
         avs_response <= 2'b00;
         if (avs_address == `FPS_CTRL_OFS)
         begin
            rdata_r[1:0] <= ctrl_r;
         end
         else if (avs_address == `FPS_STAT_OFS)
         begin
            rdata_r[`FPS_STAT_OK_BIT] <= ok_r;
            rdata_r[`FPS_STAT_OV_BIT] <= ov_r;
            rdata_r[`FPS_STAT_OC_BIT] <= overcurrent_fault;
            rdata_r[`FPS_STAT_UV_BIT] <= ~uv_above_in;
            rdata_r[`FPS_STAT_LOCK_BIT] <= (state_r == FPS_ST_LOCK);
            rdata_r[`FPS_STAT_CNT_LSB +: 3] <= retry_r;
            rdata_r[`FPS_STAT_ST_LSB +: 3] <= state_r;
         end
         else if (avs_address == `FPS_CFG_OFS)
         begin
            rdata_r[3:0] <= cfg_r;
         end
         else
         begin
            avs_response <= 2'b11;
         end
      end
   end
   assign avs_readdata = rdata_r;

endmodule

// File: verification/fps_supervisor_chk.sv
// Purpose: Concurrent checks on the supervisor ports
// Assumes: One clock domain, resetn asynchronous and active low
// Notes: Bound into every fps_supervisor instance
`timescale 1ns/1ps
module fps_supervisor_chk
#(
   parameter int NUM_PHASES = 4,
   parameter int PH_DIV = 25
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic enable_in,
   input wire logic uv_above_in,
   input wire logic ov_trip_in,
   input wire logic ref_stepping_in,
   input wire fps_pkg::fps_phase_t phase_state [NUM_PHASES],
   input wire logic supply_ok_out,
   input wire logic crowbar_trigger,
   input wire logic overcurrent_fault,
   input wire logic undervoltage_fault,
   input wire logic overvoltage_fault,
   input wire logic phase_clk_en
);
   import fps_pkg::*;
   // ----------------------------------------
   // Hiccup wait length counter
   // ----------------------------------------
   logic [12:0] wait_cnt_r; // Phase pulses seen while tripped
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // Saturates so a stuck fault cannot wrap back into range
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
         wait_cnt_r <= 13'h0;
      else if (!overcurrent_fault)
         wait_cnt_r <= 13'h0;
      else if (phase_clk_en && wait_cnt_r != 13'h1FFF)
         wait_cnt_r <= wait_cnt_r + 13'h1;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_uv_flag: assert property (undervoltage_fault == !uv_above_in)
      else $error("uv flag wrong");
   a_ok_needs_above: assert property ($rose(supply_ok_out) |-> $past(uv_above_in))
      else $error("ok rose below threshold");
   a_uv_drops_ok: assert property (undervoltage_fault && enable_in |=> !supply_ok_out)
      else $error("ok held during uv");
   a_ov_ok_low: assert property (overvoltage_fault |=> !supply_ok_out)
      else $error("ok high while ov latched");
   a_ov_clamp_low: assert property ($rose(overvoltage_fault) |-> ##[0:1]
      (phase_state[0] == FPS_PH_LOW && phase_state[NUM_PHASES-1] == FPS_PH_LOW))
      else $error("ov did not clamp");
   a_ov_over_oc: assert property (overvoltage_fault && ov_trip_in && enable_in
      |=> phase_state[0] == FPS_PH_LOW)
      else $error("ov repeat not low");
   a_crowbar_ov: assert property (crowbar_trigger == overvoltage_fault)
      else $error("crowbar mismatch");
   a_oc_tristate: assert property ($rose(overcurrent_fault) && !overvoltage_fault
      |-> ##[0:1] (phase_state[0] == FPS_PH_HIZ && !supply_ok_out))
      else $error("oc not tristated");
   a_oc_blanked: assert property (ref_stepping_in && !overcurrent_fault
      |=> !overcurrent_fault)
      else $error("oc not blanked");
   a_hiccup_len: assert property ($fell(overcurrent_fault) && enable_in && $past(enable_in)
      |-> wait_cnt_r inside {[13'h7FF:13'h801]})
      else $error("hiccup wait length wrong");
   c_ov: cover property ($rose(overvoltage_fault));
   c_oc: cover property ($rose(overcurrent_fault));
   c_ok: cover property ($rose(supply_ok_out));
endmodule

bind fps_supervisor fps_supervisor_chk #(.NUM_PHASES(NUM_PHASES), .PH_DIV(PH_DIV)) i_chk
   (.clk_sys, .resetn, .enable_in, .uv_above_in, .ov_trip_in, .ref_stepping_in,
    .phase_state, .supply_ok_out, .crowbar_trigger, .overcurrent_fault,
    .undervoltage_fault, .overvoltage_fault, .phase_clk_en);

// File: verification/fps_rail_model.sv
// Purpose: Output rail and comparators beyond the supervisor
// Assumes: Phase 0 stands for the drivers of every phase
// Notes: Clamp pulls the rail 100 mV a clock; hi-Z holds it
`timescale 1ns/1ps
module fps_rail_model
(
   input wire logic clk_sys,
   input wire fps_pkg::fps_phase_t drive_state,
   input wire logic load_en,
   input wire logic [11:0] load_mv,
   input wire logic [11:0] ref_mv,
   output logic uv_above,
   output logic ov_trip,
   output logic at_ref
);
   import fps_pkg::*;
   logic [11:0] rail_r = 12'h0; // Rail level in mV
   // Bench loads a level; lower switches on drain it
   always @(posedge clk_sys)
      if (load_en)
         rail_r <= load_mv;
      else if (drive_state == FPS_PH_LOW)
         rail_r <= (rail_r > 12'h64) ? rail_r - 12'h64 : 12'h0;
   assign uv_above = (rail_r + 350) > ref_mv;
   assign ov_trip = rail_r >= 12'h898;
   assign at_ref = rail_r <= ref_mv;
endmodule

// File: verification/fps_supervisor_tb.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Phase divider cut to 2 to keep 2048-pulse waits short
// Notes: Rail model supplies the uv, ov and at-reference comparator results
`timescale 1ns/1ps
`include "fps_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module fps_supervisor_tb;
   import fps_pkg::*;
   localparam int PHD = 2; // Short phase clock
   localparam int NPH = 4;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic enable_in = 1'b1;
   logic por_ok_in = 1'b1;
   logic oc_trip_in = 1'b0;
   logic ref_stepping_in = 1'b0;
   logic uv_above_in, ov_trip_in, at_ref_in;
   fps_phase_t phase_state [NPH];
   logic supply_ok_out, crowbar_trigger, overcurrent_fault;
   logic undervoltage_fault, overvoltage_fault;
   logic load_en = 1'b0;
   logic [11:0] load_mv = 12'h0;
   logic [31:0] q; // Last read data
   logic [1:0] r; // Last response
   int error_cnt = 0;
   int comparisons = 0;
   // ----------------------------------------
   // Design, rail model, clock
   // ----------------------------------------
   fps_supervisor #(.NUM_PHASES(NPH), .PH_DIV(PHD)) i_dut (.clk_sys(clk_sys),
      .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .enable_in(enable_in), .por_ok_in(por_ok_in), .uv_above_in(uv_above_in),
      .ov_trip_in(ov_trip_in), .at_ref_in(at_ref_in), .oc_trip_in(oc_trip_in),
      .ref_stepping_in(ref_stepping_in), .phase_state(phase_state),
      .supply_ok_out(supply_ok_out), .crowbar_trigger(crowbar_trigger),
      .overcurrent_fault(overcurrent_fault), .undervoltage_fault(undervoltage_fault),
      .overvoltage_fault(overvoltage_fault), .phase_clk_en());
   fps_rail_model i_rail (.clk_sys(clk_sys), .drive_state(phase_state[0]),
      .load_en(load_en), .load_mv(load_mv), .ref_mv(12'h4B0), .uv_above(uv_above_in),
      .ov_trip(ov_trip_in), .at_ref(at_ref_in));
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      // Answer taken at the very edge that sees waitrequest low
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rail(input logic [11:0] mv);
      @(posedge clk_sys);
      load_mv <= mv;
      load_en <= 1'b1;
      @(posedge clk_sys);
      load_en <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Polls state field; the watchdog bounds a hang
   task automatic wait_st(input fps_state_t st);
      do bus(1'b0, `FPS_STAT_OFS, 32'h0, 4'hF);
      while (q[14:12] !== st);
   endtask
   // One-cycle over-current pulse; all phases go hi-Z
   task automatic trip;
      @(posedge clk_sys);
      oc_trip_in <= 1'b1;
      @(posedge clk_sys);
      oc_trip_in <= 1'b0;
      cyc(1);
      `CHK(phase_state[NPH-1], FPS_PH_HIZ)
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      bus(1'b0, `FPS_CFG_OFS, 32'h0, 4'hF);
      `CHK(q[3:0], `FPS_CFG_RST)
      bus(1'b1, `FPS_CTRL_OFS, 32'h1, 4'h0); // Lane 0 off: dropped
      bus(1'b0, `FPS_CTRL_OFS, 32'h0, 4'hF);
      `CHK(q[1:0], `FPS_CTRL_RST)
      `CHK(supply_ok_out, 1'b0)
      bus(1'b1, 4'hC, 32'hF, 4'hF);
      `CHK(r, 2'h3)
      $display("regs done");
   endtask
   task automatic t_start;
      rail(12'h4B0);
      bus(1'b1, `FPS_CTRL_OFS, 32'h1, 4'hF);
      wait_st(FPS_ST_RUN);
      `CHK(supply_ok_out, 1'b1)
      `CHK(phase_state[0], FPS_PH_NORMAL)
      $display("start done");
   endtask
   // Threshold edge: 850 + 350 equals reference, still under
   task automatic t_uv;
      rail(12'h352);
      cyc(2);
      `CHK(supply_ok_out, 1'b0)
      `CHK(undervoltage_fault, 1'b1)
      `CHK(phase_state[0], FPS_PH_NORMAL)
      rail(12'h353);
      cyc(2);
      `CHK(supply_ok_out, 1'b1)
      $display("uv done");
   endtask
   task automatic t_dis;
      @(posedge clk_sys);
      enable_in <= 1'b0;
      cyc(4);
      `CHK(supply_ok_out, 1'b1)
      rail(12'h320);
      cyc(2);
      `CHK(supply_ok_out, 1'b0)
      @(posedge clk_sys);
      enable_in <= 1'b1;
      rail(12'h4B0);
      wait_st(FPS_ST_RUN);
      $display("disable done");
   endtask
   task automatic t_blank;
      @(posedge clk_sys);
      ref_stepping_in <= 1'b1;
      oc_trip_in <= 1'b1;
      cyc(20);
      `CHK(overcurrent_fault, 1'b0)
      @(posedge clk_sys);
      oc_trip_in <= 1'b0;
      ref_stepping_in <= 1'b0;
      $display("blank done");
   endtask
   task automatic t_ov;
      rail(12'h8FC);
      cyc(2);
      `CHK({overvoltage_fault, crowbar_trigger, supply_ok_out}, 3'b110)
      `CHK(phase_state[NPH-1], FPS_PH_LOW)
      cyc(20);
      `CHK(phase_state[0], FPS_PH_HIZ)
      @(posedge clk_sys);
      oc_trip_in <= 1'b1;
      rail(12'h8CA);
      // Comparator settles after the load edge; clamp lands one edge later
      cyc(2);
      `CHK(phase_state[0], FPS_PH_LOW)
      @(posedge clk_sys);
      oc_trip_in <= 1'b0;
      cyc(20);
      `CHK({overvoltage_fault, supply_ok_out}, 2'b10)
      @(posedge clk_sys);
      por_ok_in <= 1'b0;
      cyc(2);
      `CHK(crowbar_trigger, 1'b0)
      @(posedge clk_sys);
      por_ok_in <= 1'b1;
      wait_st(FPS_ST_RUN);
      $display("ov done");
   endtask
   task automatic t_hic;
      int n;
      n = 0;
      trip();
      while (overcurrent_fault === 1'b1 && n < 5000)
      begin
         n++;
         cyc(1);
      end
      `CHK(n > 2048 * PHD - 4 && n < 2048 * PHD + 4, 1'b1)
      trip();
      wait_st(FPS_ST_RUN);
      `CHK({q[10:8], supply_ok_out}, 4'h1)
      trip();
      for (int k = 1; k <= 8; k++)
      begin
         wait_st(FPS_ST_SOFT);
         trip();
         bus(1'b0, `FPS_STAT_OFS, 32'h0, 4'hF);
         `CHK(q[4], k == 8)
      end
      enable_in <= 1'b0;
      cyc(3);
      @(posedge clk_sys);
      enable_in <= 1'b1;
      bus(1'b0, `FPS_STAT_OFS, 32'h0, 4'hF);
      `CHK(q[4], 1'b0)
      $display("hiccup done");
   endtask
   // ----------------------------------------
   // Run and verdict
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_start();
      t_uv();
      t_dis();
      t_blank();
      t_ov();
      t_hic();
      tally_and_finish();
   end
   // About 57k cycles expected; cut a hang short
   initial
   begin
      repeat (97000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
endmodule
